// ---- bdw_blend.v ----
/*
 * One colour channel of the two-source alpha blend, result registered.
 * Assumes the weight code is held stable by the caller during a transfer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bdw_consts.vh"

module bdw_blend #(
   parameter CW = 8
) (
   // clock and reset
   input  wire          pclk,
   input  wire          presetn,
   input  wire          ce,
   // operands
   input  wire [5:0]    weight_code,
   input  wire [CW-1:0] src0,
   input  wire [CW-1:0] src1,
   input  wire          load,
   // result
   output reg  [CW-1:0] mixed
);

   wire [5:0]    weight;
   wire [5:0]    inv_weight;
   wire [CW+5:0] prod0;
   wire [CW+5:0] prod1;
   wire [CW+6:0] sum;

   // code 2Xh means a full weight of one, below that code/32
   assign weight     = weight_code[`BDW_BLEND_FULL_BIT] ? `BDW_BLEND_ONE :
                       {1'b0, weight_code[`BDW_BLEND_FRAC_MSB:0]};
   assign inv_weight = `BDW_BLEND_ONE - weight;
   assign prod0      = src0 * inv_weight;
   assign prod1      = src1 * weight;
   assign sum        = {1'b0, prod0} + {1'b0, prod1};

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mixed <= {CW{1'b0}};
      end else if (ce && load) begin
         mixed <= sum[CW+`BDW_BLEND_SHIFT-1:`BDW_BLEND_SHIFT];
      end
   end

endmodule
`default_nettype wire

// ---- bdw_cfg.v ----
/*
 * Destination canvas, transfer window and alpha blend configuration for the
 * block transfer engine, with an APB slave and the per-pixel blend datapath.
 * Reads answer with no wait state unless ce was low on their setup or access edge.
 * Assumes the engine pulses op_start and op_done, and that inputs are
 * synchronous to pclk.
 */
//
// Contract
// - canvas width: low bits 7:2, high 4:0
// - window X: low byte, high bits 4:0
// - window Y: low byte, high bits 4:0
// - pattern fill forces transfer width 8/16
// - pattern fill forces transfer height 8/16
// - blend code below 20h is code/32, 2Xh one
// - output is src0*(1-w) plus src1*w
// - config registers reset to zero, read/write
`timescale 1ns/1ps
`default_nettype none
`include "bdw_consts.vh"

module bdw_cfg #(
   parameter ADDR_W = 12,
   parameter CW     = 8,
   parameter NCH    = 3
) (
   // clock, reset, enable
   input  wire                pclk,
   input  wire                presetn,
   input  wire                ce,
   // apb slave
   input  wire                psel,
   input  wire                penable,
   input  wire                pwrite,
   input  wire [ADDR_W-1:0]   paddr,
   input  wire [31:0]         pwdata,
   input  wire [3:0]          pstrb,
   output wire                pready,
   output reg  [31:0]         prdata,
   output wire                pslverr,
   // engine control
   input  wire                op_start,
   input  wire                op_done,
   input  wire                pattern_fill,
   input  wire                pattern_large,
   output reg                 busy,
   // geometry held for the running operation
   output reg  [12:0]         dest_canvas_width,
   output reg  [12:0]         dest_window_x,
   output reg  [12:0]         dest_window_y,
   output reg  [12:0]         transfer_window_width,
   output reg  [12:0]         transfer_window_height,
   output reg  [5:0]          blend_weight,
   // pixel blend
   input  wire                pix_valid,
   input  wire [NCH*CW-1:0]   first_source,
   input  wire [NCH*CW-1:0]   second_source,
   output reg                 mix_valid,
   output wire [NCH*CW-1:0]   mix_pixel
);

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   reg  [15:0] reg_canvas_w;
   reg  [15:0] reg_win_x;
   reg  [15:0] reg_win_y;
   reg  [15:0] reg_xfer_w;
   reg  [15:0] reg_xfer_h;
   reg  [5:0]  reg_blend;

   wire [9:0]  word_idx;
   wire        hit_canvas_w;
   wire        hit_win_x;
   wire        hit_win_y;
   wire        hit_xfer_w;
   wire        hit_xfer_h;
   wire        hit_blend;
   wire        hit_status;
   wire        mapped;
   wire        aligned;
   wire        wr_en;
   wire        xfer_end;
   wire        rd_take;
   reg         rd_valid;
   wire        wr_canvas_w;
   wire        wr_win_x;
   wire        wr_win_y;
   wire        wr_xfer_w;
   wire        wr_xfer_h;
   wire        wr_blend;

   assign word_idx     = paddr[`BDW_ADDR_MSB:`BDW_IDX_LSB];
   assign aligned      = (paddr[`BDW_IDX_LSB-1:0] == 2'h0);
   assign hit_canvas_w = aligned && (word_idx == `BDW_IDX_CANVAS_W);
   assign hit_win_x    = aligned && (word_idx == `BDW_IDX_WIN_X);
   assign hit_win_y    = aligned && (word_idx == `BDW_IDX_WIN_Y);
   assign hit_xfer_w   = aligned && (word_idx == `BDW_IDX_XFER_W);
   assign hit_xfer_h   = aligned && (word_idx == `BDW_IDX_XFER_H);
   assign hit_blend    = aligned && (word_idx == `BDW_IDX_BLEND);
   assign hit_status   = aligned && (word_idx == `BDW_IDX_STATUS);
   assign mapped       = hit_canvas_w | hit_win_x | hit_win_y | hit_xfer_w |
                         hit_xfer_h | hit_blend | hit_status;

   // writes wait only while ce is low; a read waits until its data is captured, so a
   // setup edge lost to a low ce costs one wait state
   assign pready   = ce && (pwrite || rd_valid);
   assign pslverr  = psel && penable && !mapped;
   assign xfer_end = psel && penable && pready;
   assign rd_take  = ce && psel && !pwrite && !rd_valid;
   assign wr_en    = xfer_end && pwrite && mapped;

   // one strobe per register
   assign wr_canvas_w = wr_en && hit_canvas_w;
   assign wr_win_x    = wr_en && hit_win_x;
   assign wr_win_y    = wr_en && hit_win_y;
   assign wr_xfer_w   = wr_en && hit_xfer_w;
   assign wr_xfer_h   = wr_en && hit_xfer_h;
   assign wr_blend    = wr_en && hit_blend && pstrb[`BDW_LANE_LO];

   // byte-lane merge for a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] wd;
      input [3:0]  st;
      begin
         merge16[`BDW_LO_MSB:0] = st[`BDW_LANE_LO] ? wd[`BDW_LO_MSB:0] :
                                  old[`BDW_LO_MSB:0];
         merge16[`BDW_REG_MSB:`BDW_HI_LSB] = st[`BDW_LANE_HI] ?
                                             wd[`BDW_REG_MSB:`BDW_HI_LSB] :
                                             old[`BDW_REG_MSB:`BDW_HI_LSB];
      end
   endfunction

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_canvas_w <= `BDW_RST_GEOM;
         reg_win_x    <= `BDW_RST_GEOM;
         reg_win_y    <= `BDW_RST_GEOM;
         reg_xfer_w   <= `BDW_RST_GEOM;
         reg_xfer_h   <= `BDW_RST_GEOM;
         reg_blend    <= `BDW_RST_BLEND;
      end else begin
         if (wr_canvas_w) begin
            reg_canvas_w <= merge16(reg_canvas_w, pwdata, pstrb);
         end
         if (wr_win_x) begin
            reg_win_x <= merge16(reg_win_x, pwdata, pstrb);
         end
         if (wr_win_y) begin
            reg_win_y <= merge16(reg_win_y, pwdata, pstrb);
         end
         if (wr_xfer_w) begin
            reg_xfer_w <= merge16(reg_xfer_w, pwdata, pstrb);
         end
         if (wr_xfer_h) begin
            reg_xfer_h <= merge16(reg_xfer_h, pwdata, pstrb);
         end
         if (wr_blend) begin
            reg_blend <= pwdata[`BDW_BLEND_MSB:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path: data captured on the first enabled edge of the read

   reg [31:0] next_prdata;

   always @* begin
      next_prdata = `BDW_RST_WORD;
      if (hit_canvas_w) begin
         next_prdata = {16'h0000, reg_canvas_w};
      end else if (hit_win_x) begin
         next_prdata = {16'h0000, reg_win_x};
      end else if (hit_win_y) begin
         next_prdata = {16'h0000, reg_win_y};
      end else if (hit_xfer_w) begin
         next_prdata = {16'h0000, reg_xfer_w};
      end else if (hit_xfer_h) begin
         next_prdata = {16'h0000, reg_xfer_h};
      end else if (hit_blend) begin
         next_prdata = {26'h0000000, reg_blend};
      end else if (hit_status) begin
         next_prdata[`BDW_STAT_BUSY] = busy;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `BDW_RST_WORD;
      end else if (rd_take) begin
         prdata <= next_prdata;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_valid <= 1'b0;
      end else if (ce) begin
         if (!psel || xfer_end) begin
            rd_valid <= 1'b0;
         end else if (rd_take) begin
            rd_valid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // field extraction; high-byte bits 7:5 have no effect

   wire [12:0] live_canvas_w;
   wire [12:0] live_win_x;
   wire [12:0] live_win_y;
   wire [12:0] live_xfer_w;
   wire [12:0] live_xfer_h;
   wire [12:0] pat_size;

   // low two bits of the canvas width are not used
   assign live_canvas_w = {reg_canvas_w[`BDW_HI_MSB:`BDW_HI_LSB],
                           reg_canvas_w[`BDW_LO_MSB:`BDW_WIDTH_LSB],
                           2'h0};
   assign live_win_x    = reg_win_x[`BDW_HI_MSB:0];
   assign live_win_y    = reg_win_y[`BDW_HI_MSB:0];
   assign pat_size      = pattern_large ? `BDW_PAT_LARGE : `BDW_PAT_SMALL;
   assign live_xfer_w   = pattern_fill ? pat_size :
                          reg_xfer_w[`BDW_HI_MSB:0];
   assign live_xfer_h   = pattern_fill ? pat_size :
                          reg_xfer_h[`BDW_HI_MSB:0];

   ////////////////////////////////////////////////////////////////////////////
   // operation snapshot

   wire launch;
   reg  next_busy;

   assign launch = op_start && !busy;

   // start wins over done; a start while busy is ignored
   always @* begin
      next_busy = busy;
      if (launch) begin
         next_busy = 1'b1;
      end else if (op_done) begin
         next_busy = 1'b0;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy                   <= 1'b0;
         dest_canvas_width      <= `BDW_RST_FIELD;
         dest_window_x          <= `BDW_RST_FIELD;
         dest_window_y          <= `BDW_RST_FIELD;
         transfer_window_width  <= `BDW_RST_FIELD;
         transfer_window_height <= `BDW_RST_FIELD;
         blend_weight           <= `BDW_RST_BLEND;
      end else if (ce) begin
         busy <= next_busy;
         if (launch) begin
            // later register writes wait for the next operation
            dest_canvas_width      <= live_canvas_w;
            dest_window_x          <= live_win_x;
            dest_window_y          <= live_win_y;
            transfer_window_width  <= live_xfer_w;
            transfer_window_height <= live_xfer_h;
            blend_weight           <= reg_blend;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // blend datapath, one channel per instance

   wire pix_load;

   assign pix_load = pix_valid && busy;

   genvar ch;
   generate
      for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
         bdw_blend #(
            .CW (CW)
         ) i_bdw_blend (
            .pclk        (pclk),
            .presetn     (presetn),
            .ce          (ce),
            .weight_code (blend_weight),
            .src0        (first_source[ch*CW +: CW]),
            .src1        (second_source[ch*CW +: CW]),
            .load        (pix_load),
            .mixed       (mix_pixel[ch*CW +: CW])
         );
      end
   endgenerate

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mix_valid <= 1'b0;
      end else if (ce) begin
         mix_valid <= pix_load;
      end
   end

endmodule
`default_nettype wire

// ---- bdw_cfg_properties.sv ----
/*
 * Checker for the destination window and blend configuration block.
 * Assumes it is bound to bdw_cfg and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module bdw_cfg_props #(
   parameter ADDR_W = 12,
   parameter CW     = 8,
   parameter NCH    = 3
) (
   // clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              ce,
   // apb
   input wire logic              psel,
   input wire logic              penable,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              pslverr,
   // engine
   input wire logic              op_start,
   input wire logic              op_done,
   input wire logic              pattern_fill,
   input wire logic              pattern_large,
   input wire logic              busy,
   input wire logic [12:0]       dest_canvas_width,
   input wire logic [12:0]       transfer_window_width,
   input wire logic [12:0]       transfer_window_height,
   input wire logic [5:0]        blend_weight,
   // pixel
   input wire logic              pix_valid,
   input wire logic [NCH*CW-1:0] first_source,
   input wire logic [NCH*CW-1:0] second_source,
   input wire logic              mix_valid,
   input wire logic [NCH*CW-1:0] mix_pixel
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire launch = op_start && !busy && ce;
   wire pix    = pix_valid && busy && ce;
   ////////////////////////////////////////////////////////////////////////////
   property p_launch; launch |=> busy; endproperty
   a_launch: assert property (p_launch) else $error("busy not raised at launch");
   property p_done; busy && op_done && !op_start && ce |=> !busy; endproperty
   a_done: assert property (p_done) else $error("busy not cleared by done");
   property p_hold;
      busy ##1 busy |-> $stable(dest_canvas_width) && $stable(blend_weight)
         && $stable(transfer_window_width);
   endproperty
   a_hold: assert property (p_hold) else $error("snapshot moved while busy");
   property p_align; dest_canvas_width[1:0] == 2'b00; endproperty
   a_align: assert property (p_align) else $error("canvas width low bits set");
   property p_pat_w;
      launch && pattern_fill |=>
         transfer_window_width == ($past(pattern_large) ? 13'h0010 : 13'h0008);
   endproperty
   a_pat_w: assert property (p_pat_w) else $error("pattern width wrong");
   property p_pat_h;
      launch && pattern_fill |=>
         transfer_window_height == ($past(pattern_large) ? 13'h0010 : 13'h0008);
   endproperty
   a_pat_h: assert property (p_pat_h) else $error("pattern height wrong");
   property p_full; pix && blend_weight[5] |=> mix_pixel == $past(second_source); endproperty
   a_full: assert property (p_full) else $error("full weight not source 1");
   property p_zero; pix && blend_weight == 6'h00 |=> mix_pixel == $past(first_source); endproperty
   a_zero: assert property (p_zero) else $error("zero weight not source 0");
   property p_mixv;
      pix |=> mix_valid ##1 (!mix_valid || $past(pix) || !$past(ce));
   endproperty
   a_mixv: assert property (p_mixv) else $error("mix valid timing wrong");
   property p_err; psel && penable && paddr[1:0] != 2'b00 |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("unaligned access not refused");
   c_pat: cover property (launch && pattern_fill);
   c_full: cover property (pix && blend_weight[5]);
   c_err: cover property (psel && penable && pslverr);
endmodule
bind bdw_cfg bdw_cfg_props #(.ADDR_W(ADDR_W), .CW(CW), .NCH(NCH)) i_bdw_cfg_props (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .paddr(paddr), .pslverr(pslverr), .op_start(op_start), .op_done(op_done),
   .pattern_fill(pattern_fill), .pattern_large(pattern_large), .busy(busy),
   .dest_canvas_width(dest_canvas_width), .transfer_window_width(transfer_window_width),
   .transfer_window_height(transfer_window_height), .blend_weight(blend_weight),
   .pix_valid(pix_valid), .first_source(first_source), .second_source(second_source),
   .mix_valid(mix_valid), .mix_pixel(mix_pixel));
`default_nettype wire

// ---- bdw_cfg_tb.sv ----
/*
 * Self-checking testbench for bdw_cfg over APB with engine and pixel stimulus.
 * Assumes default parameters; ce is high except in the freeze scenario.
 */
`timescale 1ns/1ps
`default_nettype none
`include "bdw_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
   $display("[FAIL] %0t got %0h expected %0h", $time, a, b); end end
module bdw_cfg_tb;
   logic        pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, op_start = 1'b0, op_done = 1'b0, pix_valid = 1'b0;
   logic        pattern_fill = 1'b0, pattern_large = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, r;
   logic [3:0]  pstrb = 4'h0;
   logic [23:0] first_source = 24'h0, second_source = 24'h0;
   logic        e;
   wire         pready, pslverr, busy, mix_valid;
   wire [31:0]  prdata;
   wire [12:0]  dest_canvas_width, dest_window_x, dest_window_y;
   wire [12:0]  transfer_window_width, transfer_window_height;
   wire [5:0]   blend_weight;
   wire [23:0]  mix_pixel;
   int          error_cnt = 0, n_checks = 0;
   logic [9:0]  idx_t [6] = '{`BDW_IDX_CANVAS_W, `BDW_IDX_WIN_X, `BDW_IDX_WIN_Y,
                              `BDW_IDX_XFER_W, `BDW_IDX_XFER_H, `BDW_IDX_BLEND};
   logic [31:0] wv [6] = '{32'h0000FFFC, 32'h0000F234, 32'h00002ABC,
                           32'h0000E0FF, 32'h00001F01, 32'h0000002A};
   bdw_cfg i_bdw_cfg (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .op_start(op_start),
      .op_done(op_done), .pattern_fill(pattern_fill), .pattern_large(pattern_large),
      .busy(busy), .dest_canvas_width(dest_canvas_width), .dest_window_x(dest_window_x),
      .dest_window_y(dest_window_y), .transfer_window_width(transfer_window_width),
      .transfer_window_height(transfer_window_height), .blend_weight(blend_weight),
      .pix_valid(pix_valid), .first_source(first_source), .second_source(second_source),
      .mix_valid(mix_valid), .mix_pixel(mix_pixel));
   initial forever #10 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [11:0] ba(input logic [9:0] idx);
      return {idx, 2'b00};
   endfunction
   function automatic logic [7:0] mix(input logic [7:0] a, b, input logic [5:0] c);
      int w;
      w = c[5] ? 32 : int'(c);
      return 8'((int'(a) * (32 - w) + int'(b) * w) >> 5);
   endfunction
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int k;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) begin error_cnt++; close_out; end
      r = prdata; e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic go;
      @(posedge pclk); op_start <= 1'b1;
      @(posedge pclk); op_start <= 1'b0;
      #1;
   endtask
   task automatic stop;
      @(posedge pclk); op_done <= 1'b1;
      @(posedge pclk); op_done <= 1'b0;
      #1;
      `CHK(busy, 1'b0)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ba(idx_t[i]), 32'h0, 4'h0);
         `CHK(r, 32'h0)
      end
   endtask
   task automatic t_rw;
      for (int i = 0; i < 6; i++) apb(1'b1, ba(idx_t[i]), wv[i] | 32'hFFFF0000, 4'h3);
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ba(idx_t[i]), 32'h0, 4'h0);
         `CHK(r, wv[i])
      end
      apb(1'b1, ba(idx_t[0]), 32'h0, 4'h2);
      apb(1'b0, ba(idx_t[0]), 32'h0, 4'h0);
      `CHK(r, 32'h000000FC)
      apb(1'b1, ba(idx_t[0]), 32'hFFFF, 4'h2);
   endtask
   task automatic t_launch;
      go;
      `CHK(busy, 1'b1)
      `CHK(dest_canvas_width, 13'h1FFC)
      `CHK(dest_window_x, 13'h1234)
      `CHK(dest_window_y, 13'h0ABC)
      `CHK(transfer_window_width, 13'h00FF)
      `CHK(transfer_window_height, 13'h1F01)
      `CHK(blend_weight, 6'h2A)
      apb(1'b1, ba(idx_t[1]), 32'h0, 4'h3);
      apb(1'b0, ba(`BDW_IDX_STATUS), 32'h0, 4'h0);
      `CHK(r, 32'h1)
      go;
      `CHK(dest_window_x, 13'h1234)
      stop;
   endtask
   task automatic t_pat;
      for (int k = 0; k < 2; k++) begin
         @(posedge pclk); pattern_fill <= 1'b1; pattern_large <= k[0];
         go;
         `CHK(transfer_window_width, k ? 13'h0010 : 13'h0008)
         `CHK(transfer_window_height, k ? 13'h0010 : 13'h0008)
         stop;
      end
      pattern_fill <= 1'b0;
   endtask
   task automatic t_blend;
      logic [5:0] c [5] = '{6'h00, 6'h01, 6'h10, 6'h1F, 6'h2F};
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, ba(`BDW_IDX_BLEND), {26'h0, c[i]}, 4'h1);
         go;
         @(posedge pclk); pix_valid <= 1'b1;
         first_source <= 24'hF08010; second_source <= 24'h0F40FF;
         @(posedge pclk); pix_valid <= 1'b0;
         #1;
         `CHK(mix_valid, 1'b1)
         for (int h = 0; h < 3; h++)
            `CHK(mix_pixel[h*8+:8], mix(first_source[h*8+:8], second_source[h*8+:8], c[i]))
         stop;
      end
   endtask
   task automatic t_bad;
      apb(1'b0, ba(10'h0AC), 32'h0, 4'h0);
      `CHK(e, 1'b1)
      `CHK(r, 32'h0)
      apb(1'b1, 12'h2AD, 32'h0, 4'h3);
      `CHK(e, 1'b1)
      apb(1'b0, ba(idx_t[0]), 32'h0, 4'h0);
      `CHK(r, 32'h0000FFFC)
   endtask
   task automatic t_freeze;
      @(posedge pclk); ce <= 1'b0;
      go;
      `CHK(busy, 1'b0)
      fork
         apb(1'b0, ba(idx_t[3]), 32'h0, 4'h0);
         begin repeat (4) @(posedge pclk); ce <= 1'b1; end
      join
      `CHK(r, wv[3])
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_rw;
      t_launch;
      t_pat;
      t_blend;
      t_bad;
      t_freeze;
      close_out;
   end
endmodule
`default_nettype wire

// ---- bdw_consts.vh ----
/*
 * Constants for the destination window and alpha blend configuration block:
 * register indices, field positions, reset values and blend arithmetic.
 * Assumes it is included by its bare name from the design files.
 */
`ifndef BDW_CONSTS_VH
`define BDW_CONSTS_VH

// register indices; the byte address is four times the index
`define BDW_IDX_CANVAS_W   10'h0AB
`define BDW_IDX_WIN_X      10'h0AD
`define BDW_IDX_WIN_Y      10'h0AF
`define BDW_IDX_XFER_W     10'h0B1
`define BDW_IDX_XFER_H     10'h0B3
`define BDW_IDX_BLEND      10'h0B5
`define BDW_IDX_STATUS     10'h0C0

// address decode: word index above the byte offset
`define BDW_ADDR_MSB       11
`define BDW_IDX_LSB        2

// byte lanes of a 16-bit register
`define BDW_LANE_LO        0
`define BDW_LANE_HI        1
`define BDW_REG_MSB        15

// reset values
`define BDW_RST_GEOM       16'h0000
`define BDW_RST_BLEND      6'h00
`define BDW_RST_FIELD      13'h0000
`define BDW_RST_WORD       32'h00000000

// field layout of a 16-bit geometry register
`define BDW_LO_MSB         7
`define BDW_HI_LSB         8
`define BDW_HI_MSB         12
`define BDW_WIDTH_LSB      2

// blend weight code
`define BDW_BLEND_MSB      5
`define BDW_BLEND_FULL_BIT 5
`define BDW_BLEND_FRAC_MSB 4
`define BDW_BLEND_ONE      6'h20
`define BDW_BLEND_SHIFT    5

// pattern-fill forced window sizes
`define BDW_PAT_SMALL      13'h0008
`define BDW_PAT_LARGE      13'h0010

// status register fields
`define BDW_STAT_BUSY      0

`endif
